// ==== rtl/crfr_pkg.sv ====
// Constants for the codec routing and flag register bank.
// Assumes one core clock and an asynchronous active-low reset in every clocked RTL user; crfr_route has neither.
//
// How it works
// - Route bit 7 picks primary bit clock: 0 internal, 1 secondary bit clock.
// - Route bit 6 picks secondary bit clock: 0 primary clock, 1 internal.
// - Route bits 5:4 pick primary frame clock: playback, record, secondary, reserved.
// - Route bits 3:2 pick secondary frame clock: primary, playback, record, reserved.
// - Route bit 1 picks primary data out: 0 codec serial output, 1 secondary input.
// - Route bit 0 picks secondary data out: 0 primary input, 1 codec serial output.
// - General-call bit 5 accepts the general-call address when 1; resets to 0.
// - Record status bit 7 shows gain match, bit 6 shows converter powered.
// - Record status bit 5 latches when automatic gain reaches its maximum.
// - Playback power status shows converter and driver power per channel.
// - Playback gain status bits 4 and 0 show per-channel gain match.
// - Overflow bits 7,6,5 latch playback converter and shifter overflows.
// - Overflow bits 3,1 latch record overflows; bits 4,2,0 are reserved.
// - Sticky flags are read-only and clear when read.
// - Event bits 7,6 latch left and right driver short circuits.
// - Event bits 5,4 latch button press and headset insert or remove.
// - Event bits 3,2 latch when channel power is strictly above threshold.
// - Event bits 1,0 latch ones written to the standard and auxiliary ports.
package crfr_pkg;
  localparam logic [7:0] OFF_ROUTE = 8'h21;
  localparam logic [7:0] OFF_GCALL = 8'h22;
  localparam logic [7:0] OFF_RSVD35 = 8'h23;
  localparam logic [7:0] OFF_REC = 8'h24;
  localparam logic [7:0] OFF_PWR = 8'h25;
  localparam logic [7:0] OFF_GAIN = 8'h26;
  localparam logic [7:0] OFF_OVF = 8'h27;
  localparam logic [7:0] OFF_RSVD40 = 8'h28;
  localparam logic [7:0] OFF_EVT = 8'h2C;

  localparam int ROUTE_PBCLK = 7;
  localparam int ROUTE_SBCLK = 6;
  localparam int ROUTE_PWCLK_LO = 4;
  localparam int ROUTE_SWCLK_LO = 2;
  localparam int ROUTE_PSDO = 1;
  localparam int ROUTE_SSDO = 0;
  localparam int GCALL_BIT = 5;
  localparam int REC_GAIN = 7;
  localparam int REC_PWR = 6;
  localparam int REC_AGC = 5;
  localparam int GAIN_L = 4;
  localparam int GAIN_R = 0;

  localparam int OVF_PB_L = 7;
  localparam int OVF_PB_R = 6;
  localparam int OVF_PB_SH = 5;
  localparam int OVF_REC_DS = 3;
  localparam int OVF_REC_SH = 1;
  localparam logic [7:0] OVF_USED = 8'hEA;

  localparam int EVT_SHORT_L = 7;
  localparam int EVT_SHORT_R = 6;
  localparam int EVT_BUTTON = 5;
  localparam int EVT_HEADSET = 4;
  localparam int EVT_DRC_L = 3;
  localparam int EVT_DRC_R = 2;
  localparam int EVT_STD = 1;
  localparam int EVT_AUX = 0;

  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic GCALL_RST = 1'b0;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    PWCLK_PLAY = 2'h0,
    PWCLK_REC = 2'h1,
    PWCLK_SEC = 2'h2,
    PWCLK_RSVD = 2'h3
  } crfr_pwclk_t;

  typedef enum logic [1:0] {
    SWCLK_PRI = 2'h0,
    SWCLK_PLAY = 2'h1,
    SWCLK_REC = 2'h2,
    SWCLK_RSVD = 2'h3
  } crfr_swclk_t;
endpackage

// ==== rtl/crfr_flag_if.sv ====
// Bundle between the register bank and one sticky flag group.
// Assumes the owner updates the flags on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface crfr_flag_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic clr;
  logic [W-1:0] q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface
`default_nettype wire

// ==== rtl/crfr_sticky.sv ====
// Sticky flag group that clears on read.
// Assumes clr is a one-cycle read strobe on the core clock.
`timescale 1ns/1ps
`default_nettype none
module crfr_sticky #(parameter int W = 8) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Flags
  crfr_flag_if.owner f
);
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      f.q <= W'(crfr_pkg::FLAG_RST);
    end else begin
      // Set beats clear so an event during the read is kept.
      f.q <= f.set | (f.q & ~{W{f.clr}});
    end
  end

  set_wins_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (f.clr && |f.set) |=> ((f.q & $past(f.set)) == $past(f.set)))
    else $error("flag set during clearing read was lost");
endmodule
`default_nettype wire

// ==== rtl/crfr_route.sv ====
// Combinational selection of serial port clocks and data.
// Assumes all sources are sampled levels on the core clock.
`timescale 1ns/1ps
`default_nettype none
module crfr_route (
  // Routing control
  input wire logic [7:0] cfg_in,
  // Clock sources
  input wire logic int_bclk_in,
  input wire logic pri_bclk_in,
  input wire logic sec_bclk_in,
  input wire logic play_fs_in,
  input wire logic rec_fs_in,
  input wire logic pri_wclk_in,
  input wire logic sec_wclk_in,
  // Data sources
  input wire logic codec_sdo_in,
  input wire logic pri_sdi_in,
  input wire logic sec_sdi_in,
  // Selected values
  output logic pri_bclk_out,
  output logic sec_bclk_out,
  output logic pri_wclk_out,
  output logic sec_wclk_out,
  output logic pri_sdo_out,
  output logic sec_sdo_out
);
  crfr_pkg::crfr_pwclk_t psel;
  crfr_pkg::crfr_swclk_t ssel;

  always_comb begin
    psel = crfr_pkg::crfr_pwclk_t'(cfg_in[crfr_pkg::ROUTE_PWCLK_LO +: 2]);
    ssel = crfr_pkg::crfr_swclk_t'(cfg_in[crfr_pkg::ROUTE_SWCLK_LO +: 2]);
    pri_bclk_out = cfg_in[crfr_pkg::ROUTE_PBCLK] ? sec_bclk_in : int_bclk_in;
    sec_bclk_out = cfg_in[crfr_pkg::ROUTE_SBCLK] ? int_bclk_in : pri_bclk_in;
    pri_sdo_out = cfg_in[crfr_pkg::ROUTE_PSDO] ? sec_sdi_in : codec_sdo_in;
    sec_sdo_out = cfg_in[crfr_pkg::ROUTE_SSDO] ? codec_sdo_in : pri_sdi_in;
    // Reserved codes hold the frame clock low.
    unique case (psel)
      crfr_pkg::PWCLK_PLAY: pri_wclk_out = play_fs_in;
      crfr_pkg::PWCLK_REC: pri_wclk_out = rec_fs_in;
      crfr_pkg::PWCLK_SEC: pri_wclk_out = sec_wclk_in;
      crfr_pkg::PWCLK_RSVD: pri_wclk_out = 1'b0;
    endcase
    unique case (ssel)
      crfr_pkg::SWCLK_PRI: sec_wclk_out = pri_wclk_in;
      crfr_pkg::SWCLK_PLAY: sec_wclk_out = play_fs_in;
      crfr_pkg::SWCLK_REC: sec_wclk_out = rec_fs_in;
      crfr_pkg::SWCLK_RSVD: sec_wclk_out = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/crfr_top.sv ====
// Register bank for serial port routing, general-call enable and status flags.
// Assumes a register port driven by the device's serial control decoder:
// one-cycle read and write strobes with address and data on the core clock.
`timescale 1ns/1ps
`default_nettype none
module crfr_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Serial port sources
  input wire logic int_bclk_in,
  input wire logic pri_bclk_in,
  input wire logic sec_bclk_in,
  input wire logic playback_sample_rate_clock_in,
  input wire logic record_sample_rate_clock_in,
  input wire logic pri_wclk_in,
  input wire logic sec_wclk_in,
  input wire logic codec_serial_data_output_in,
  input wire logic pri_serial_data_input_in,
  input wire logic sec_serial_data_input_in,
  // Serial port outputs
  output logic pri_bclk_out,
  output logic sec_bclk_out,
  output logic pri_wclk_out,
  output logic sec_wclk_out,
  output logic pri_serial_data_output_out,
  output logic sec_serial_data_output_out,
  // Two-wire bus control
  output logic general_call_accept_out,
  // Record path status
  input wire logic rec_gain_stage_match_in,
  input wire logic rec_converter_up_in,
  input wire logic agc_at_max_in,
  // Playback power and gain status
  input wire logic [2:0] left_power_in,
  input wire logic [2:0] right_power_in,
  input wire logic left_gain_match_in,
  input wire logic right_gain_match_in,
  // Overflow sources
  input wire logic ovf_play_left_in,
  input wire logic ovf_play_right_in,
  input wire logic ovf_play_shifter_in,
  input wire logic ovf_rec_converter_in,
  input wire logic ovf_rec_shifter_in,
  // Playback events
  input wire logic short_left_in,
  input wire logic short_right_in,
  input wire logic button_press_in,
  input wire logic headset_change_in,
  input wire logic [7:0] drc_power_left_in,
  input wire logic [7:0] drc_power_right_in,
  input wire logic [7:0] drc_threshold_in,
  input wire logic dsp_port_wr_in,
  input wire logic dsp_std_bit_in,
  input wire logic dsp_aux_bit_in
);
  logic [7:0] route_r;
  logic gcall_r;
  logic pb_n, sb_n, pw_n, sw_n, psd_n, ssd_n;
  logic [7:0] rd_value;
  logic ovf_read, evt_read, rec_read;

  // True when the strobe targets the given offset.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // Strictly above threshold; equal does not count.
  function automatic logic above(input logic [7:0] level, input logic [7:0] thr);
    return level > thr;
  endfunction

  crfr_flag_if #(.W(1)) agc_f ();
  crfr_flag_if #(.W(8)) ovf_f ();
  crfr_flag_if #(.W(8)) evt_f ();

  crfr_sticky #(.W(1)) u_agc (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .f(agc_f.owner)
  );
  crfr_sticky #(.W(8)) u_ovf (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .f(ovf_f.owner)
  );
  crfr_sticky #(.W(8)) u_evt (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .f(evt_f.owner)
  );

  crfr_route u_route (
    .cfg_in(route_r),
    .int_bclk_in(int_bclk_in),
    .pri_bclk_in(pri_bclk_in),
    .sec_bclk_in(sec_bclk_in),
    .play_fs_in(playback_sample_rate_clock_in),
    .rec_fs_in(record_sample_rate_clock_in),
    .pri_wclk_in(pri_wclk_in),
    .sec_wclk_in(sec_wclk_in),
    .codec_sdo_in(codec_serial_data_output_in),
    .pri_sdi_in(pri_serial_data_input_in),
    .sec_sdi_in(sec_serial_data_input_in),
    .pri_bclk_out(pb_n),
    .sec_bclk_out(sb_n),
    .pri_wclk_out(pw_n),
    .sec_wclk_out(sw_n),
    .pri_sdo_out(psd_n),
    .sec_sdo_out(ssd_n)
  );

  assign rec_read = reg_rd_in && hit(reg_addr_in, crfr_pkg::OFF_REC);
  assign ovf_read = reg_rd_in && hit(reg_addr_in, crfr_pkg::OFF_OVF);
  assign evt_read = reg_rd_in && hit(reg_addr_in, crfr_pkg::OFF_EVT);

  // Sticky sources. Reserved overflow positions are never set.
  always_comb begin
    agc_f.set = agc_at_max_in;
    agc_f.clr = rec_read;
    ovf_f.set = 8'h00;
    ovf_f.set[crfr_pkg::OVF_PB_L] = ovf_play_left_in;
    ovf_f.set[crfr_pkg::OVF_PB_R] = ovf_play_right_in;
    ovf_f.set[crfr_pkg::OVF_PB_SH] = ovf_play_shifter_in;
    ovf_f.set[crfr_pkg::OVF_REC_DS] = ovf_rec_converter_in;
    ovf_f.set[crfr_pkg::OVF_REC_SH] = ovf_rec_shifter_in;
    ovf_f.clr = ovf_read;
    evt_f.set[crfr_pkg::EVT_SHORT_L] = short_left_in;
    evt_f.set[crfr_pkg::EVT_SHORT_R] = short_right_in;
    evt_f.set[crfr_pkg::EVT_BUTTON] = button_press_in;
    evt_f.set[crfr_pkg::EVT_HEADSET] = headset_change_in;
    evt_f.set[crfr_pkg::EVT_DRC_L] = above(drc_power_left_in, drc_threshold_in);
    evt_f.set[crfr_pkg::EVT_DRC_R] = above(drc_power_right_in, drc_threshold_in);
    evt_f.set[crfr_pkg::EVT_STD] = dsp_port_wr_in && dsp_std_bit_in;
    evt_f.set[crfr_pkg::EVT_AUX] = dsp_port_wr_in && dsp_aux_bit_in;
    evt_f.clr = evt_read;
  end

  // Writable controls. Status, sticky and reserved offsets ignore writes.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      route_r <= crfr_pkg::ROUTE_RST;
      gcall_r <= crfr_pkg::GCALL_RST;
    end else if (reg_wr_in) begin
      if (hit(reg_addr_in, crfr_pkg::OFF_ROUTE)) begin
        route_r <= reg_wdata_in;
      end
      if (hit(reg_addr_in, crfr_pkg::OFF_GCALL)) begin
        gcall_r <= reg_wdata_in[crfr_pkg::GCALL_BIT];
      end
    end
  end

  // Read multiplexer; unmapped and reserved offsets read zero.
  always_comb begin
    rd_value = 8'h00;
    unique case (reg_addr_in)
      crfr_pkg::OFF_ROUTE: rd_value = route_r;
      crfr_pkg::OFF_GCALL: rd_value[crfr_pkg::GCALL_BIT] = gcall_r;
      crfr_pkg::OFF_REC: begin
        rd_value[crfr_pkg::REC_GAIN] = rec_gain_stage_match_in;
        rd_value[crfr_pkg::REC_PWR] = rec_converter_up_in;
        rd_value[crfr_pkg::REC_AGC] = agc_f.q[0];
      end
      crfr_pkg::OFF_PWR: rd_value = {left_power_in[2], 1'b0, left_power_in[1:0],
                                     right_power_in[2], 1'b0, right_power_in[1:0]};
      crfr_pkg::OFF_GAIN: begin
        rd_value[crfr_pkg::GAIN_L] = left_gain_match_in;
        rd_value[crfr_pkg::GAIN_R] = right_gain_match_in;
      end
      crfr_pkg::OFF_OVF: rd_value = ovf_f.q & crfr_pkg::OVF_USED;
      crfr_pkg::OFF_EVT: rd_value = evt_f.q;
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= crfr_pkg::RDATA_RST;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_value;
      end
    end
  end

  // Port outputs are retimed so that each comes straight from a flop.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pri_bclk_out <= 1'b0;
      sec_bclk_out <= 1'b0;
      pri_wclk_out <= 1'b0;
      sec_wclk_out <= 1'b0;
      pri_serial_data_output_out <= 1'b0;
      sec_serial_data_output_out <= 1'b0;
    end else begin
      pri_bclk_out <= pb_n;
      sec_bclk_out <= sb_n;
      pri_wclk_out <= pw_n;
      sec_wclk_out <= sw_n;
      pri_serial_data_output_out <= psd_n;
      sec_serial_data_output_out <= ssd_n;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      general_call_accept_out <= crfr_pkg::GCALL_RST;
    end else begin
      general_call_accept_out <= gcall_r;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  pri_bclk_route_a: assert property (
    1'b1 |=> pri_bclk_out == ($past(route_r[7]) ? $past(sec_bclk_in) : $past(int_bclk_in)))
    else $error("primary bit clock took the wrong source");
  sec_bclk_route_a: assert property (
    1'b1 |=> sec_bclk_out == ($past(route_r[6]) ? $past(int_bclk_in) : $past(pri_bclk_in)))
    else $error("secondary bit clock took the wrong source");
  pri_wclk_sec_a: assert property (
    (route_r[5:4] == 2'h2) |=> pri_wclk_out == $past(sec_wclk_in))
    else $error("primary frame clock did not follow secondary frame clock");
  sec_wclk_rec_a: assert property (
    (route_r[3:2] == 2'h2) |=> sec_wclk_out == $past(record_sample_rate_clock_in))
    else $error("secondary frame clock did not follow record rate clock");
  wclk_reserved_a: assert property (
    (route_r[3:2] == 2'h3 && route_r[5:4] == 2'h3) |=> !sec_wclk_out && !pri_wclk_out)
    else $error("reserved frame clock code drove a clock");
  pri_sdo_route_a: assert property (
    route_r[1] |=> pri_serial_data_output_out == $past(sec_serial_data_input_in))
    else $error("primary data out did not pass secondary input");
  sec_sdo_route_a: assert property (
    !route_r[0] |=> sec_serial_data_output_out == $past(pri_serial_data_input_in))
    else $error("secondary data out did not pass primary input");
  gcall_write_a: assert property (
    (reg_wr_in && reg_addr_in == 8'h22) |-> ##2 general_call_accept_out == $past(reg_wdata_in[5], 2))
    else $error("general-call enable did not take the written bit");
  rec_status_a: assert property (
    (reg_rd_in && reg_addr_in == 8'h24) |=>
      reg_rvalid_out && reg_rdata_out[7:6] == {$past(rec_gain_stage_match_in),
                                               $past(rec_converter_up_in)})
    else $error("record status read wrong");
  agc_sticky_a: assert property (
    (agc_at_max_in && !rec_read) ##1 !rec_read ##1 (reg_rd_in && reg_addr_in == 8'h24) |=>
      reg_rdata_out[5])
    else $error("automatic gain maximum was not latched");
  power_read_a: assert property (
    (reg_rd_in && reg_addr_in == 8'h25) |=>
      reg_rdata_out == {$past(left_power_in[2]), 1'b0, $past(left_power_in[1:0]),
                        $past(right_power_in[2]), 1'b0, $past(right_power_in[1:0])})
    else $error("playback power read wrong");
  gain_read_a: assert property (
    (reg_rd_in && reg_addr_in == 8'h26) |=>
      reg_rdata_out == {3'h0, $past(left_gain_match_in), 3'h0, $past(right_gain_match_in)})
    else $error("playback gain read wrong");
  ovf_reserved_a: assert property (
    (reg_rd_in && reg_addr_in == 8'h27) |=> (reg_rdata_out & 8'h15) == 8'h00)
    else $error("reserved overflow bit read as one");
  ovf_latch_a: assert property (
    ovf_play_shifter_in |=> ovf_f.q[5])
    else $error("playback shifter overflow was not latched");
  read_clears_a: assert property (
    (evt_read && evt_f.set == 8'h00) ##1 (evt_f.set == 8'h00) |=> evt_f.q == 8'h00)
    else $error("event flags survived a clearing read");
  drc_equal_a: assert property (
    (drc_power_left_in == drc_threshold_in && !$past(evt_f.q[3]) && !evt_f.q[3]) |=> !evt_f.q[3])
    else $error("power equal to threshold set the compression flag");
  short_latch_a: assert property (
    (short_right_in || (evt_f.q[6] && !evt_read)) |=> evt_f.q[6])
    else $error("short circuit flag did not hold");
  port_write_a: assert property (
    (dsp_port_wr_in && dsp_aux_bit_in) |=> evt_f.q[0])
    else $error("auxiliary port write was not latched");
  event_keep_a: assert property (
    (evt_read && headset_change_in) |=> evt_f.q[4])
    else $error("headset event lost during read");

  rd_evt_c: cover property (evt_read ##1 reg_rvalid_out && reg_rdata_out != 8'h00);
  route_all_c: cover property (reg_wr_in && reg_addr_in == 8'h21 && reg_wdata_in == 8'hFF);
  gcall_on_c: cover property ($rose(general_call_accept_out));
  clash_c: cover property (ovf_read && ovf_play_left_in);
endmodule
`default_nettype wire

// ==== tb/crfr_host.sv ====
// Host model that reaches the register bank through its register port.
// Assumes the bank answers a read with rvalid one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module crfr_host (
  // Clock
  input wire logic mclk_in,
  // Read answer
  input wire logic reg_rvalid_in,
  input wire logic [7:0] reg_rdata_in,
  // Request
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_out <= a;
    // Reserved bits of the general-call register only ever get zeros.
    reg_wdata_out <= (a == crfr_pkg::OFF_GCALL) ? (d & 8'h20) : d;
    reg_wr_out <= 1'b1;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge mclk_in);
    reg_rd_out <= 1'b0;
    @(posedge mclk_in);
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
  endtask
endmodule
`default_nettype wire

// ==== tb/crfr_top_bench.sv ====
// Self-checking bench for the routing and flag register bank.
// Assumes the host model drives the register port; sources are driven here.
`timescale 1ns/1ps
`default_nettype none
module crfr_top_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rvalid, gcall;
  logic [9:0] src = 10'h000;
  logic [12:0] evt = 13'h0000;
  logic rec_match = 1'b0, rec_up = 1'b0, lg = 1'b0, rg = 1'b0;
  logic [2:0] lp = 3'h0, rp = 3'h0;
  logic [7:0] thr = 8'h00, pl = 8'h00, pr = 8'h00;
  logic [5:0] route_o;
  int err_count = 0;
  int n_checks = 0;

  always #10 mclk = ~mclk;

  crfr_host crfr_host_i (.mclk_in(mclk), .reg_rvalid_in(rvalid), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

  crfr_top crfr_top_i (.mclk_in(mclk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .int_bclk_in(src[9]), .pri_bclk_in(src[8]),
    .sec_bclk_in(src[7]), .playback_sample_rate_clock_in(src[6]),
    .record_sample_rate_clock_in(src[5]), .pri_wclk_in(src[4]), .sec_wclk_in(src[3]),
    .codec_serial_data_output_in(src[2]), .pri_serial_data_input_in(src[1]),
    .sec_serial_data_input_in(src[0]), .pri_bclk_out(route_o[5]),
    .sec_bclk_out(route_o[4]), .pri_wclk_out(route_o[3]), .sec_wclk_out(route_o[2]),
    .pri_serial_data_output_out(route_o[1]), .sec_serial_data_output_out(route_o[0]),
    .general_call_accept_out(gcall), .rec_gain_stage_match_in(rec_match),
    .rec_converter_up_in(rec_up), .agc_at_max_in(evt[12]), .left_power_in(lp),
    .right_power_in(rp), .left_gain_match_in(lg), .right_gain_match_in(rg),
    .ovf_play_left_in(evt[11]), .ovf_play_right_in(evt[10]),
    .ovf_play_shifter_in(evt[9]), .ovf_rec_converter_in(evt[8]),
    .ovf_rec_shifter_in(evt[7]), .short_left_in(evt[6]), .short_right_in(evt[5]),
    .button_press_in(evt[4]), .headset_change_in(evt[3]), .drc_power_left_in(pl),
    .drc_power_right_in(pr), .drc_threshold_in(thr), .dsp_port_wr_in(evt[2]),
    .dsp_std_bit_in(evt[1]), .dsp_aux_bit_in(evt[0]));

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    crfr_host_i.rd(a, d);
    chk($sformatf("register %h", a), exp, d);
  endtask

  // Source order is {int, pri, sec bit clock, play, rec, pri, sec frame, codec, pri, sec data}.
  function automatic logic [5:0] route_exp(input logic [7:0] c, input logic [9:0] s);
    logic [3:0] pf;
    logic [3:0] sf;
    pf = {1'b0, s[3], s[5], s[6]};
    sf = {1'b0, s[5], s[6], s[4]};
    return {c[7] ? s[7] : s[9], c[6] ? s[9] : s[8], pf[c[5:4]], sf[c[3:2]],
      c[1] ? s[0] : s[2], c[0] ? s[2] : s[1]};
  endfunction

  task automatic test_reset;
    for (int a = 8'h21; a <= 8'h2C; a++) begin
      rdchk(a[7:0], 8'h00);
    end
    chk("general call", 8'h00, {7'h00, gcall});
  endtask

  task automatic test_route;
    logic [7:0] codes [5] = '{8'h00, 8'h55, 8'hAA, 8'hC3, 8'h3C};
    logic [9:0] p;
    foreach (codes[i]) begin
      crfr_host_i.wr(crfr_pkg::OFF_ROUTE, codes[i]);
      rdchk(crfr_pkg::OFF_ROUTE, codes[i]);
      for (int k = 0; k < 4; k++) begin
        p = k[1] ? 10'h020 : 10'h244;
        if (k[0]) begin
          p = ~p;
        end
        @(posedge mclk);
        src <= p;
        repeat (3) @(posedge mclk);
        chk("route", {2'b00, route_exp(codes[i], p)}, {2'b00, route_o});
      end
    end
  endtask

  task automatic test_gcall;
    crfr_host_i.wr(crfr_pkg::OFF_GCALL, 8'h20);
    repeat (3) @(posedge mclk);
    chk("general call", 8'h01, {7'h00, gcall});
    rdchk(crfr_pkg::OFF_GCALL, 8'h20);
    crfr_host_i.wr(crfr_pkg::OFF_GCALL, 8'h00);
    repeat (3) @(posedge mclk);
    chk("general call", 8'h00, {7'h00, gcall});
  endtask

  task automatic test_status;
    @(posedge mclk);
    {rec_match, rec_up, lp, rp, lg, rg} <= {2'b11, 3'b101, 3'b010, 2'b10};
    rdchk(crfr_pkg::OFF_REC, 8'hC0);
    rdchk(crfr_pkg::OFF_PWR, 8'h92);
    rdchk(crfr_pkg::OFF_GAIN, 8'h10);
    @(posedge mclk);
    {rec_match, rec_up, lp, rp, lg, rg} <= {2'b10, 3'b010, 3'b101, 2'b01};
    rdchk(crfr_pkg::OFF_REC, 8'h80);
    rdchk(crfr_pkg::OFF_PWR, 8'h29);
    rdchk(crfr_pkg::OFF_GAIN, 8'h01);
    @(posedge mclk);
    {rec_match, rec_up, lp, rp, lg, rg} <= 10'h000;
    rdchk(8'h30, 8'h00);
  endtask

  task automatic test_sticky;
    logic [12:0] s [13] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080,
      13'h0040, 13'h0020, 13'h0010, 13'h0008, 13'h0006, 13'h0005, 13'h0004};
    logic [7:0] e [13] = '{8'h20, 8'h80, 8'h40, 8'h20, 8'h08, 8'h02, 8'h80, 8'h40, 8'h20,
      8'h10, 8'h02, 8'h01, 8'h00};
    foreach (s[i]) begin
      @(posedge mclk);
      evt <= s[i];
      @(posedge mclk);
      evt <= 13'h0000;
      if (i == 0) begin
        rdchk(crfr_pkg::OFF_REC, e[i]);
      end else begin
        rdchk(i < 6 ? crfr_pkg::OFF_OVF : crfr_pkg::OFF_EVT, e[i]);
      end
      rdchk(i == 0 ? crfr_pkg::OFF_REC : i < 6 ? crfr_pkg::OFF_OVF : crfr_pkg::OFF_EVT,
        8'h00);
    end
  endtask

  task automatic test_drc;
    @(posedge mclk);
    {thr, pl, pr} <= {8'h80, 8'h80, 8'h81};
    @(posedge mclk);
    {pl, pr} <= 16'h0000;
    rdchk(crfr_pkg::OFF_EVT, 8'h04);
    @(posedge mclk);
    {pl, pr} <= {8'h81, 8'h80};
    @(posedge mclk);
    {pl, pr} <= 16'h0000;
    rdchk(crfr_pkg::OFF_EVT, 8'h08);
  endtask

  // The source is still high at the edge that takes the clearing read.
  task automatic test_set_wins;
    logic [7:0] d;
    @(posedge mclk);
    evt <= 13'h0048;
    fork
      crfr_host_i.rd(crfr_pkg::OFF_EVT, d);
      begin
        repeat (2) @(posedge mclk);
        evt <= 13'h0000;
      end
    join
    chk("set wins", 8'h90, d);
    rdchk(crfr_pkg::OFF_EVT, 8'h90);
    rdchk(crfr_pkg::OFF_EVT, 8'h00);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    test_reset();
    test_route();
    test_gcall();
    test_status();
    test_sticky();
    test_drc();
    test_set_wins();
    stop_test();
  end
endmodule
`default_nettype wire
